// ---- sram_port_pkg.sv ----
package sram_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int WORD_W      = 36;
  localparam int ADDR_W      = 20;
  localparam int BURST_LEN   = 4;
  localparam int BEAT_W      = 2;
  localparam int MEM_ADDR_W  = 8;
  localparam int MEM_DEPTH   = 256;
  localparam int FIFO_DEPTH  = 8;
  localparam int IR_W        = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Beat slots and counts
  localparam logic [BEAT_W-1:0] PH_RD_ADDR     = 2'h0;
  localparam logic [BEAT_W-1:0] PH_WR_ADDR     = 2'h2;
  localparam logic [BEAT_W-1:0] BEAT_ONE       = 2'h1;
  localparam logic [BEAT_W-1:0] WAIT_ZERO      = 2'h0;
  localparam logic [BEAT_W-1:0] IDX_ZERO       = 2'h0;
  localparam logic [BEAT_W-1:0] LAST_IDX       = 2'h3;
  // Wait after capture: latency in beats minus one
  localparam logic [BEAT_W-1:0] LAT_LONG_WAIT  = 2'h2;
  localparam logic [BEAT_W-1:0] LAT_SHORT_WAIT = 2'h1;
  localparam logic [1:0]        ECHO_RESET     = 2'h2;
  localparam logic [IR_W-1:0]   IR_CAPTURE     = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [BURST_LEN-1:0][WORD_W-1:0] burst_t;

  typedef struct packed {
    logic              rd_sel_n;
    logic              wr_sel_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } link_in_t;

  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR  = 4'hB,
    TAP_EX1_IR = 4'hC, TAP_PAU_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
  } tap_state_t;

  typedef struct packed {
    logic [BEAT_W-1:0] phase;
    logic              mode_meta;
    logic              mode_sync;
    logic              rd_busy;
    logic [ADDR_W-1:0] rd_addr;
    logic [BEAT_W-1:0] rd_wait;
    logic [BEAT_W-1:0] rd_idx;
    logic              nx_valid;
    logic [ADDR_W-1:0] nx_addr;
    logic [BEAT_W-1:0] nx_wait;
    logic              refused;
    logic              wr_open;
    logic [ADDR_W-1:0] wr_addr;
    logic [BEAT_W-1:0] wr_idx;
    logic [BURST_LEN-1:0] wr_vld;
    burst_t            wr_buf;
    logic              cm_valid;
    logic [ADDR_W-1:0] cm_addr;
    burst_t            cm_buf;
  } link_state_t;

  typedef struct packed {
    logic [WORD_W-1:0] rdata;
    logic              rvalid;
    logic [1:0]        echo;
    logic              tck_meta;
    logic              tck_sync;
    logic              tck_prev;
    logic              tms_meta;
    logic              tms_sync;
    logic              tdi_meta;
    logic              tdi_sync;
    tap_state_t        tap;
    logic [IR_W-1:0]   ir_sh;
    logic              bypass;
    logic              tdo;
    logic              tdo_oe;
  } out_state_t;

endpackage

// ---- async_word_fifo.sv ----
`timescale 1ns/1ps
module async_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             wr_clk_i,
  input  wire logic             wr_rst_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_clk_i,
  input  wire logic             rd_rst_i,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] PTR_ONE = 1;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] peer_meta;
    logic [AW:0] peer_sync;
  } side_t;

  side_t            w_q;
  side_t            w_d;
  side_t            r_q;
  side_t            r_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             w_fire;
  logic             r_fire;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Fill side
  assign wr_ready_o = w_q.gray != {~w_q.peer_sync[AW:AW-1], w_q.peer_sync[AW-2:0]};
  assign w_fire     = wr_valid_i && wr_ready_o;

  always_comb begin
    w_d           = w_q;
    w_d.peer_meta = r_q.gray;
    w_d.peer_sync = w_q.peer_meta;
    if (w_fire) begin
      w_d.bin  = w_q.bin + PTR_ONE;
      w_d.gray = to_gray(w_d.bin);
    end
  end

  always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
    if (wr_rst_i) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
  end

  always_ff @(posedge wr_clk_i) begin
    if (w_fire) begin
      mem[w_q.bin[AW-1:0]] <= wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drain side
  assign rd_valid_o = r_q.gray != r_q.peer_sync;
  assign rd_data_o  = mem[r_q.bin[AW-1:0]];
  assign r_fire     = rd_valid_o && rd_ready_i;

  always_comb begin
    r_d           = r_q;
    r_d.peer_meta = w_q.gray;
    r_d.peer_sync = r_q.peer_meta;
    if (r_fire) begin
      r_d.bin  = r_q.bin + PTR_ONE;
      r_d.gray = to_gray(r_d.bin);
    end
  end

  always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
    if (rd_rst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

endmodule

// ---- separate_io_ddr_burst_sram_port.sv ----
// How it works
// - Read and write ports run independently, concurrently
// - Every accepted address moves a four-word burst
// - Read and write addresses on alternating slots
// - One data word per beat, one beat per link clock cycle
// - Rising clock edges only
// - Mode pin high: three-beat read latency
// - Mode pin low: two-beat read latency
// - All link inputs registered on link clock
// - Read data launched from output-clock registers
// - Writes committed by internal self-timed stage
// - Separate selects start each port independently
// - Reads return newest data, even in flight
// - Echo strobe pair toggles with read data
// - Boundary-scan test port with bypass path
`timescale 1ns/1ps
module separate_io_ddr_burst_sram_port
  import sram_port_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              link_clk_i,
  input  wire link_in_t          link_i,
  input  wire logic              pll_bypass_select_i,
  input  wire logic              rd_pause_i,
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  output logic [WORD_W-1:0]      rdata_o,
  output logic                   rdata_valid_o,
  output logic [1:0]             echo_strobe_pair_o,
  output logic                   rd_refused_o,
  output logic                   tdo_o,
  output logic                   tdo_oe_o
);

  logic              lrst_meta_q;
  logic              lrst_q;
  link_state_t       s_q;
  link_state_t       s_d;
  out_state_t        o_q;
  out_state_t        o_d;
  burst_t            mem [MEM_DEPTH];
  burst_t            mem_burst;
  logic [WORD_W-1:0] push_data;
  logic [BEAT_W-1:0] lat_wait;
  logic              rd_take;
  logic              wr_take;
  logic              push_valid;
  logic              push_fire;
  logic              rd_last;
  logic              fifo_ready;
  logic              fifo_rvalid;
  logic [WORD_W-1:0] fifo_rdata;
  logic              pop;
  logic              tck_rise;
  logic              tck_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Link-domain reset release
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lrst_meta_q <= 1'h1;
      lrst_q      <= 1'h1;
    end else begin
      lrst_meta_q <= 1'h0;
      lrst_q      <= lrst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address slots and read latency
  assign rd_take    = (s_q.phase == PH_RD_ADDR) && !link_i.rd_sel_n;
  assign wr_take    = (s_q.phase == PH_WR_ADDR) && !link_i.wr_sel_n;
  assign lat_wait   = s_q.mode_sync ? LAT_LONG_WAIT : LAT_SHORT_WAIT;
  assign push_valid = s_q.rd_busy && (s_q.rd_wait == WAIT_ZERO);
  assign push_fire  = push_valid && fifo_ready;
  assign rd_last    = push_fire && (s_q.rd_idx == LAST_IDX);
  assign mem_burst  = mem[s_q.rd_addr[MEM_ADDR_W-1:0]];

  // Newest copy of the word wins: open burst, then pending commit, then array
  always_comb begin
    push_data = mem_burst[s_q.rd_idx];
    if (s_q.cm_valid && (s_q.cm_addr == s_q.rd_addr)) begin
      push_data = s_q.cm_buf[s_q.rd_idx];
    end
    if (s_q.wr_open && (s_q.wr_addr == s_q.rd_addr) && s_q.wr_vld[s_q.rd_idx]) begin
      push_data = s_q.wr_buf[s_q.rd_idx];
    end
  end

  always_comb begin
    s_d           = s_q;
    s_d.phase     = s_q.phase + BEAT_ONE;
    s_d.mode_meta = pll_bypass_select_i;
    s_d.mode_sync = s_q.mode_meta;
    s_d.refused   = 1'h0;
    s_d.cm_valid  = 1'h0;
    // Read engine, one word per beat
    if (s_q.nx_valid && (s_q.nx_wait != WAIT_ZERO)) begin
      s_d.nx_wait = s_q.nx_wait - BEAT_ONE;
    end
    if (s_q.rd_busy && (s_q.rd_wait != WAIT_ZERO)) begin
      s_d.rd_wait = s_q.rd_wait - BEAT_ONE;
    end
    if (push_fire) begin
      s_d.rd_idx = s_q.rd_idx + BEAT_ONE;
    end
    if (rd_last) begin
      s_d.rd_busy  = s_q.nx_valid;
      s_d.rd_addr  = s_q.nx_addr;
      s_d.rd_wait  = s_d.nx_wait;
      s_d.rd_idx   = IDX_ZERO;
      s_d.nx_valid = 1'h0;
    end
    if (rd_take) begin
      if (!s_d.rd_busy) begin
        s_d.rd_busy = 1'h1;
        s_d.rd_addr = link_i.addr;
        s_d.rd_wait = lat_wait;
        s_d.rd_idx  = IDX_ZERO;
      end else if (!s_d.nx_valid) begin
        s_d.nx_valid = 1'h1;
        s_d.nx_addr  = link_i.addr;
        s_d.nx_wait  = lat_wait;
      end else begin
        s_d.refused = 1'h1;
      end
    end
    // Write capture, independent of the read engine
    if (s_q.wr_open) begin
      s_d.wr_buf[s_q.wr_idx] = link_i.wdata;
      s_d.wr_vld[s_q.wr_idx] = 1'h1;
      s_d.wr_idx             = s_q.wr_idx + BEAT_ONE;
      if (s_q.wr_idx == LAST_IDX) begin
        s_d.wr_open  = 1'h0;
        s_d.cm_valid = 1'h1;
        s_d.cm_addr  = s_q.wr_addr;
        s_d.cm_buf   = s_d.wr_buf;
      end
    end
    if (wr_take) begin
      s_d.wr_open = 1'h1;
      s_d.wr_addr = link_i.addr;
      s_d.wr_idx  = IDX_ZERO;
      s_d.wr_vld  = '0;
    end
  end

  always_ff @(posedge link_clk_i or posedge lrst_q) begin
    if (lrst_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (s_q.cm_valid) begin
      mem[s_q.cm_addr[MEM_ADDR_W-1:0]] <= s_q.cm_buf;
    end
  end

  assign rd_refused_o = s_q.refused;

  ////////////////////////////////////////////////////////////////////////////
  // Read words into the output clock domain
  async_word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .wr_clk_i   (link_clk_i),
    .wr_rst_i   (lrst_q),
    .wr_valid_i (push_valid),
    .wr_ready_o (fifo_ready),
    .wr_data_i  (push_data),
    .rd_clk_i   (clk_i),
    .rd_rst_i   (rst_i),
    .rd_valid_o (fifo_rvalid),
    .rd_ready_i (!rd_pause_i),
    .rd_data_o  (fifo_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output registers, echo strobes and test port
  function automatic tap_state_t tap_next(input tap_state_t st, input logic tms);
    tap_state_t nx;
    nx = st;
    unique case (st)
      TAP_RESET:  nx = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nx = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nx = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  nx = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: nx = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: nx = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: nx = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nx = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: nx = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  nx = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: nx = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: nx = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: nx = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
    return nx;
  endfunction

  assign pop      = fifo_rvalid && !rd_pause_i;
  assign tck_rise = o_q.tck_sync && !o_q.tck_prev;
  assign tck_fall = !o_q.tck_sync && o_q.tck_prev;

  always_comb begin
    o_d          = o_q;
    o_d.tck_meta = tck_i;
    o_d.tck_sync = o_q.tck_meta;
    o_d.tck_prev = o_q.tck_sync;
    o_d.tms_meta = tms_i;
    o_d.tms_sync = o_q.tms_meta;
    o_d.tdi_meta = tdi_i;
    o_d.tdi_sync = o_q.tdi_meta;
    o_d.rvalid   = pop;
    if (pop) begin
      o_d.rdata = fifo_rdata;
      o_d.echo  = ~o_q.echo;
    end
    if (tck_rise) begin
      if (o_q.tap == TAP_CAP_DR) begin
        o_d.bypass = 1'h0;
      end else if (o_q.tap == TAP_SH_DR) begin
        o_d.bypass = o_q.tdi_sync;
      end else if (o_q.tap == TAP_CAP_IR) begin
        o_d.ir_sh = IR_CAPTURE;
      end else if (o_q.tap == TAP_SH_IR) begin
        o_d.ir_sh = {o_q.tdi_sync, o_q.ir_sh[IR_W-1:1]};
      end
      o_d.tap = tap_next(o_q.tap, o_q.tms_sync);
    end
    if (tck_fall) begin
      o_d.tdo    = (o_q.tap == TAP_SH_IR) ? o_q.ir_sh[0] : o_q.bypass;
      o_d.tdo_oe = (o_q.tap == TAP_SH_IR) || (o_q.tap == TAP_SH_DR);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      o_q      <= '0;
      o_q.echo <= ECHO_RESET;
    end else begin
      o_q <= o_d;
    end
  end

  assign rdata_o            = o_q.rdata;
  assign rdata_valid_o      = o_q.rvalid;
  assign echo_strobe_pair_o = o_q.echo;
  assign tdo_o              = o_q.tdo;
  assign tdo_oe_o           = o_q.tdo_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RD_LAT_LONG: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    (rd_take && !s_q.rd_busy && s_q.mode_sync) |-> ##1 !push_valid [*2] ##1 push_valid)
    else $error("long read latency not three beats");

  AST_RD_LAT_SHORT: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    (rd_take && !s_q.rd_busy && !s_q.mode_sync) |-> ##1 !push_valid ##1 push_valid)
    else $error("short read latency not two beats");

  AST_RD_SLOT: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    $rose(s_q.rd_busy) |-> ($past(s_q.phase) == PH_RD_ADDR) && !$past(link_i.rd_sel_n))
    else $error("read started outside read address slot");

  AST_NO_SEL_NO_READ: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    (!rd_take && !s_q.rd_busy && !s_q.nx_valid) |=> !s_q.rd_busy)
    else $error("read burst started without select");

  AST_BURST_END: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    (rd_last && !s_q.nx_valid && !rd_take) |=> !s_q.rd_busy)
    else $error("read burst did not end after four words");

  AST_WR_COMMIT: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    wr_take |-> ##5 s_q.cm_valid && (s_q.cm_addr == $past(link_i.addr, 5)))
    else $error("write burst not committed five beats after address");

  AST_COHERENT: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    (push_valid && s_q.cm_valid && (s_q.cm_addr == s_q.rd_addr) &&
     !(s_q.wr_open && (s_q.wr_addr == s_q.rd_addr))) |-> push_data == s_q.cm_buf[s_q.rd_idx])
    else $error("read missed data of a pending write");

  AST_LAUNCH: assert property (@(posedge clk_i) disable iff (rst_i)
    pop |=> rdata_valid_o && (rdata_o == $past(fifo_rdata)))
    else $error("read word not launched one cycle after pop");

  AST_ECHO_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(echo_strobe_pair_o) |-> rdata_valid_o && (echo_strobe_pair_o[1] != echo_strobe_pair_o[0]))
    else $error("echo strobes moved without read data");

endmodule

// ---- sram_ctrl_model.sv ----
`timescale 1ns/1ps
module sram_ctrl_model
  import sram_port_pkg::*;
(
  input  wire logic link_clk_i,
  input  wire logic rst_i,
  output link_in_t  link_o
);
  int unsigned edges;

  ////////////////////////////////////////////////////////////////////////////
  // Link edges since reset release
  always @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      edges <= 0;
    end else begin
      edges <= edges + 1;
    end
  end

  initial begin
    link_o = '{rd_sel_n: 1'b1, wr_sel_n: 1'b1, addr: '0, wdata: '0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait for the falling edge before a link edge of the given phase
  task automatic wait_slot(input int ph);
    do @(negedge link_clk_i);
    while (rst_i || edges < 3 || ((edges - 2) % 4) != ph);
  endtask

  // Read address on its own slot, select dropped at once
  task automatic read_burst(input logic [ADDR_W-1:0] a);
    wait_slot(int'(PH_RD_ADDR));
    link_o.rd_sel_n = 1'b0;
    link_o.addr     = a;
    @(negedge link_clk_i);
    link_o.rd_sel_n = 1'b1;
    link_o.addr     = ~a;
  endtask

  // Write address, then four words one per beat
  task automatic write_burst(input logic [ADDR_W-1:0] a, input burst_t d);
    wait_slot(int'(PH_WR_ADDR));
    link_o.wr_sel_n = 1'b0;
    link_o.addr     = a;
    for (int i = 0; i < BURST_LEN; i++) begin
      @(negedge link_clk_i);
      link_o.wr_sel_n = 1'b1;
      if (i == 0) begin
        link_o.addr = ~a;
      end
      link_o.wdata = d[i];
    end
    @(negedge link_clk_i);
    link_o.wdata = ~d[BURST_LEN-1];
  endtask
endmodule

// ---- separate_io_ddr_burst_sram_port_bench.sv ----
`timescale 1ns/1ps
module separate_io_ddr_burst_sram_port_bench;
  import sram_port_pkg::*;
  logic              clk_i      = 1'b0;
  logic              link_clk_i = 1'b0;
  logic              rst_i      = 1'b1;
  link_in_t          link;
  logic              pll_bypass_select_i = 1'b0;
  logic              rd_pause_i = 1'b0;
  logic              tck_i      = 1'b0;
  logic              tms_i      = 1'b1;
  logic              tdi_i      = 1'b0;
  logic [WORD_W-1:0] rdata_o;
  logic              rdata_valid_o;
  logic [1:0]        echo_strobe_pair_o;
  logic              rd_refused_o;
  logic              tdo_o;
  logic              tdo_oe_o;
  logic [1:0]        echo_prev  = ECHO_RESET;
  logic              pause_rand = 1'b0;
  logic              pause_hold = 1'b0;
  logic [WORD_W-1:0] exp_q[$];
  burst_t            mem[MEM_DEPTH];
  int                seed = 32'h581B8C0F;
  int                fails = 0;
  int                checked = 0;
  int                refusals = 0;
  int                cycles = 0;

  always #12.5 clk_i = ~clk_i;
  always #15 link_clk_i = ~link_clk_i;

  sram_ctrl_model ctrl_inst (.link_clk_i(link_clk_i), .rst_i(rst_i), .link_o(link));

  separate_io_ddr_burst_sram_port separate_io_ddr_burst_sram_port_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .link_i(link),
    .pll_bypass_select_i(pll_bypass_select_i), .rd_pause_i(rd_pause_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .echo_strobe_pair_o(echo_strobe_pair_o),
    .rd_refused_o(rd_refused_o), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o));

  ////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic check(input string what, input logic [WORD_W-1:0] seen,
                       input logic [WORD_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output watcher and pause driver
  always @(negedge clk_i) begin
    if (rdata_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("rdata_pending", WORD_W'(exp_q.size()), WORD_W'(1));
      end else begin
        check("rdata", rdata_o, exp_q.pop_front());
      end
      check("echo", WORD_W'(echo_strobe_pair_o ^ echo_prev), WORD_W'(2'h3));
      echo_prev = echo_strobe_pair_o;
    end
    rd_pause_i <= pause_rand ? 1'($random(seed)) : pause_hold;
  end

  always @(negedge link_clk_i) begin
    if (rd_refused_o === 1'b1) begin
      refusals++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Traffic tasks
  task automatic do_write(input logic [ADDR_W-1:0] a);
    burst_t d;
    for (int i = 0; i < BURST_LEN; i++) begin
      d[i] = WORD_W'({$random(seed), $random(seed)});
    end
    mem[a[MEM_ADDR_W-1:0]] = d;
    ctrl_inst.write_burst(a, d);
  endtask

  task automatic do_read(input logic [ADDR_W-1:0] a, input bit keep);
    if (keep) begin
      for (int i = 0; i < BURST_LEN; i++) begin
        exp_q.push_back(mem[a[MEM_ADDR_W-1:0]][i]);
      end
    end
    ctrl_inst.read_burst(a);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check("drain", WORD_W'(exp_q.size()), '0);
    repeat (40) @(negedge clk_i);
  endtask

  task automatic tck_pulse(input logic tms, input logic tdi, output logic tdo, output logic oe);
    tms_i = tms;
    tdi_i = tdi;
    repeat (6) @(negedge clk_i);
    tdo   = tdo_o;
    oe    = tdo_oe_o;
    tck_i = 1'b1;
    repeat (6) @(negedge clk_i);
    tck_i = 1'b0;
  endtask

  task automatic tap_bypass();
    logic       o;
    logic       e;
    logic [3:0] pat;
    logic [8:0] walk;
    pat  = 4'($random(seed));
    walk = 9'b001011111;
    for (int i = 0; i < 9; i++) begin
      tck_pulse(walk[i], 1'b0, o, e);
      if (i == 6) begin
        check("tdo_oe_idle", WORD_W'(e), '0);
      end
    end
    for (int k = 0; k < 5; k++) begin
      tck_pulse(k == 4, pat[k % 4], o, e);
      check("tdo", WORD_W'(o), WORD_W'((k == 0) ? 1'b0 : pat[(k + 3) % 4]));
      check("tdo_oe", WORD_W'(e), WORD_W'(1'b1));
    end
    // Walk to instruction shift and read back the captured pattern
    for (int i = 0; i < 5; i++) begin
      tck_pulse(i < 3, 1'b0, o, e);
    end
    for (int j = 0; j < IR_W; j++) begin
      tck_pulse(1'b0, 1'b0, o, e);
      check("tdo_ir", WORD_W'(o), WORD_W'(IR_CAPTURE[j]));
      check("tdo_oe_ir", WORD_W'(e), WORD_W'(1'b1));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    for (int m = 0; m < 2; m++) begin
      pll_bypass_select_i = m[0];
      repeat (8) @(negedge link_clk_i);
      for (int i = 0; i < 3; i++) begin
        do_write(20'hA5000 + 20'(i));
      end
      fork
        do_write(20'h3C003);
        do_read(20'hA5000, 1'b1);
      join
      do_read(20'hA5001, 1'b1);
      do_read(20'hA5002, 1'b1);
      do_read(20'h3C003, 1'b1);
      // Read slot falls inside the write burst: first words come from the open
      // burst or the pending commit, the rest from the updated array
      fork
        do_write(20'hA5001);
        begin
          #1;
          do_read(20'hA5001, 1'b1);
        end
      join
      pause_rand = 1'b1;
      drain();
      pause_rand = 1'b0;
    end
    pause_hold = 1'b1;
    for (int i = 0; i < 5; i++) begin
      do_read(20'hA5000 + 20'(i % 3), i < 4);
    end
    repeat (40) @(negedge link_clk_i);
    check("refusals", WORD_W'(refusals), WORD_W'(1));
    pause_hold = 1'b0;
    drain();
    tap_bypass();
    complete_run();
  end
endmodule
